//--- wsf_unit.sv
// weak store, fence and cache line flush logic of the load/store unit
`timescale 1ns/1ps
`include "wsf_map.svh"
module wsf_unit import wsf_pkg::*; #(
  parameter int ADDR_W = `WSF_ADDR_W,
  parameter int LINE_BYTES = `WSF_LINE_BYTES,
  parameter int CNT_W = `WSF_CNT_W,
  parameter bit EVICT_ON_NT_HIT = 1'b1
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic op_valid_i,
  output logic op_ready_o,
  input wire wsf_op_t op_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [ADDR_W-1:0] dest_index_i,
  input wire logic [`WSF_UNIT_BYTES*8-1:0] data_i,
  input wire logic [`WSF_UNIT_BYTES*8-1:0] mask_i,
  input wire wsf_mtype_t mem_type_i,
  input wire logic xlat_fault_i,
  output logic done_o,
  output logic gp_fault_o,
  output logic page_fault_o,
  output logic mem_valid_o,
  input wire logic mem_ready_i,
  output wsf_cmd_t mem_cmd_o,
  output logic [ADDR_W-1:0] mem_addr_o,
  output logic [LINE_BYTES*8-1:0] mem_wdata_o,
  output logic [LINE_BYTES-1:0] mem_be_o,
  output logic mem_alloc_o,
  output logic mem_bcast_o,
  input wire logic probe_resp_i,
  input wire logic probe_dirty_i,
  input wire logic load_vis_i,
  input wire logic store_vis_i,
  input wire logic flush_vis_i,
  input wire logic [`WSF_UNIT_BYTES*8-1:0] load_data_i,
  output logic load_valid_o,
  output logic [`WSF_UNIT_BYTES*8-1:0] load_data_o
);
  localparam int UB = `WSF_UNIT_BYTES;
  localparam int OB = `WSF_LINE_OFS_BITS;

  typedef enum logic [3:0] {
    WSF_ST_IDLE,
    WSF_ST_ISSUE,
    WSF_ST_EVICT,
    WSF_ST_DRAIN,
    WSF_ST_MERGE,
    WSF_ST_FENCE,
    WSF_ST_PROBE,
    WSF_ST_PROBE_WAIT,
    WSF_ST_WRBACK,
    WSF_ST_INVAL
  } wsf_state_t;

  // line base of an address: the low offset bits cleared
  function automatic logic [ADDR_W-1:0] wsf_line_of(input logic [ADDR_W-1:0] a);
    return {a[ADDR_W-1:OB], {OB{1'b0}}};
  endfunction

  // place a 16-byte lane at its byte offset inside a line
  function automatic logic [LINE_BYTES*8-1:0] wsf_place_data(
      input logic [UB*8-1:0] d, input logic [OB-1:0] ofs);
    logic [LINE_BYTES*8-1:0] wide;
    wide = '0;
    wide[UB*8-1:0] = d;
    return wide << {ofs, 3'b000};
  endfunction

  function automatic logic [LINE_BYTES-1:0] wsf_place_be(
      input logic [UB-1:0] be, input logic [OB-1:0] ofs);
    logic [LINE_BYTES-1:0] wide;
    wide = '0;
    wide[UB-1:0] = be;
    return wide << ofs;
  endfunction

  wsf_state_t state, next_state;
  wsf_op_t op_q, next_op_q;
  wsf_cmd_t cmd_q, next_cmd_q;
  logic [ADDR_W-1:0] addr_q, next_addr_q;
  logic [LINE_BYTES*8-1:0] data_q, next_data_q;
  logic [LINE_BYTES-1:0] be_q, next_be_q;
  logic alloc_q, next_alloc_q;
  logic done, next_done;
  logic gp_fault, next_gp_fault;
  logic page_fault, next_page_fault;
  logic [CNT_W-1:0] st_pend, next_st_pend;
  logic [CNT_W-1:0] ld_pend, next_ld_pend;
  logic [CNT_W-1:0] fl_pend, next_fl_pend;
  logic load_valid, next_load_valid;
  logic [UB*8-1:0] load_data, next_load_data;

  logic accept, fire, wc_merge, wc_clear, wc_valid;
  logic [ADDR_W-1:0] wc_line;
  logic [LINE_BYTES*8-1:0] wc_data;
  logic [LINE_BYTES-1:0] wc_be;
  logic [ADDR_W-1:0] eff_addr;
  logic [UB-1:0] lane_be;
  logic is_nt, fence_ok;

  assign op_ready_o = ce_i && (state == WSF_ST_IDLE);
  assign accept = op_valid_i && op_ready_o;
  assign fire = ce_i && mem_valid_o && mem_ready_i;

  // the write-combining line that streaming stores gather into
  wsf_wc_buffer #(
    .LINE_BYTES(LINE_BYTES),
    .ADDR_W(ADDR_W)
  ) u_wc (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .ce_i(ce_i),
    .merge_i(wc_merge),
    .clear_i(wc_clear),
    .line_addr_i(wsf_line_of(addr_q)),
    .data_i(data_q),
    .be_i(be_q),
    .valid_o(wc_valid),
    .line_addr_o(wc_line),
    .data_o(wc_data),
    .be_o(wc_be)
  );

  // masked store addresses through the index register, other ops through the operand
  always_comb begin
    eff_addr = (op_i == WSF_OP_NT_MASK) ? dest_index_i : addr_i;
    is_nt = op_i inside {WSF_OP_NT_PS, WSF_OP_NT_DQ, WSF_OP_NT_Q, WSF_OP_NT_MASK};
    lane_be = '1;
    if (op_i == WSF_OP_NT_Q) begin
      lane_be = {{(UB-`WSF_QWORD_BYTES){1'b0}}, {`WSF_QWORD_BYTES{1'b1}}};
    end else if (op_i == WSF_OP_NT_MASK) begin
      for (int i = 0; i < UB; i++) begin
        lane_be[i] = mask_i[i*8+7];
      end
    end
  end

  // load and store fences wait only on their own class and pass each other; the full fence waits on all three counters and the buffer
  always_comb begin
    unique case (op_q)
      WSF_OP_SFENCE: fence_ok = (st_pend == '0) && !wc_valid;
      WSF_OP_LFENCE: fence_ok = (ld_pend == '0);
      default: fence_ok = (st_pend == '0) && (ld_pend == '0) && (fl_pend == '0)
                          && !wc_valid;
    endcase
  end

  // request toward the hierarchy is a mux of held flops by state
  always_comb begin
    mem_valid_o = 1'b0;
    mem_cmd_o = WSF_CMD_NONE;
    mem_addr_o = wsf_line_of(addr_q);
    mem_wdata_o = data_q;
    mem_be_o = be_q;
    mem_alloc_o = 1'b0;
    mem_bcast_o = 1'b0;
    unique case (state)
      WSF_ST_ISSUE: begin
        mem_valid_o = 1'b1;
        mem_cmd_o = cmd_q;
        mem_alloc_o = alloc_q;
      end
      WSF_ST_EVICT: begin
        mem_valid_o = 1'b1;
        mem_cmd_o = WSF_CMD_EVICT;
      end
      WSF_ST_DRAIN: begin
        mem_valid_o = 1'b1;
        mem_cmd_o = WSF_CMD_WRITE_LINE;
        mem_addr_o = wc_line;
        mem_wdata_o = wc_data;
        mem_be_o = wc_be;
      end
      WSF_ST_PROBE: begin
        mem_valid_o = 1'b1;
        mem_cmd_o = WSF_CMD_PROBE;
      end
      WSF_ST_WRBACK: begin
        mem_valid_o = 1'b1;
        mem_cmd_o = WSF_CMD_WRITE_LINE;
        mem_be_o = '1;
      end
      WSF_ST_INVAL: begin
        mem_valid_o = 1'b1;
        mem_cmd_o = WSF_CMD_INVAL;
        mem_bcast_o = 1'b1;
      end
      default: begin
      end
    endcase
  end

  // main sequencer
  always_comb begin
    next_state = state;
    next_op_q = op_q;
    next_cmd_q = cmd_q;
    next_addr_q = addr_q;
    next_data_q = data_q;
    next_be_q = be_q;
    next_alloc_q = alloc_q;
    next_done = 1'b0;
    next_gp_fault = 1'b0;
    next_page_fault = 1'b0;
    wc_merge = 1'b0;
    wc_clear = 1'b0;
    unique case (state)
      WSF_ST_IDLE: begin
        if (accept) begin
          next_op_q = op_i;
          next_addr_q = eff_addr;
          next_data_q = wsf_place_data(data_i, eff_addr[OB-1:0]);
          next_be_q = wsf_place_be(lane_be, eff_addr[OB-1:0]);
          next_alloc_q = 1'b0;
          next_cmd_q = WSF_CMD_WRITE;
          if (xlat_fault_i && !(op_i inside {WSF_OP_SFENCE, WSF_OP_LFENCE, WSF_OP_MFENCE})) begin
            next_page_fault = 1'b1;
            next_done = 1'b1;
          end else if (op_i == WSF_OP_NT_PS && eff_addr[`WSF_NT_PS_ALIGN_BITS-1:0] != '0) begin
            next_gp_fault = 1'b1;
            next_done = 1'b1;
          end else if (op_i == WSF_OP_LOAD) begin
            next_cmd_q = WSF_CMD_READ;
            next_alloc_q = (mem_type_i != WSF_MT_WRITE_COMBINING_TYPE);
            next_state = WSF_ST_ISSUE;
          end else if (op_i == WSF_OP_STORE) begin
            next_alloc_q = 1'b1;
            next_state = WSF_ST_ISSUE;
          end else if (is_nt) begin
            // strongly ordered types keep their own semantics and skip combining
            if (mem_type_i inside {WSF_MT_UC, WSF_MT_WP}) begin
              next_state = WSF_ST_ISSUE;
            end else if (mem_type_i inside {WSF_MT_WB, WSF_MT_WT}) begin
              if (EVICT_ON_NT_HIT) begin
                next_state = WSF_ST_EVICT;
              end else begin
                next_cmd_q = WSF_CMD_WRITE_INPLACE;
                next_state = WSF_ST_ISSUE;
              end
            end else if (wc_valid && wc_line != wsf_line_of(eff_addr)) begin
              next_state = WSF_ST_DRAIN;
            end else begin
              next_state = WSF_ST_MERGE;
            end
          end else if (op_i == WSF_OP_FLUSH) begin
            next_state = WSF_ST_PROBE;
          end else if (op_i != WSF_OP_LFENCE && wc_valid) begin
            next_state = WSF_ST_DRAIN;
          end else begin
            next_state = WSF_ST_FENCE;
          end
        end
      end
      WSF_ST_ISSUE: begin
        if (fire) begin
          next_done = 1'b1;
          next_state = WSF_ST_IDLE;
        end
      end
      WSF_ST_EVICT: begin
        if (fire) begin
          if (wc_valid && wc_line != wsf_line_of(addr_q)) begin
            next_state = WSF_ST_DRAIN;
          end else begin
            next_state = WSF_ST_MERGE;
          end
        end
      end
      WSF_ST_DRAIN: begin
        if (fire) begin
          wc_clear = 1'b1;
          if (op_q inside {WSF_OP_SFENCE, WSF_OP_MFENCE}) begin
            next_state = WSF_ST_FENCE;
          end else begin
            next_state = WSF_ST_MERGE;
          end
        end
      end
      WSF_ST_MERGE: begin
        wc_merge = 1'b1;
        next_done = 1'b1;
        next_state = WSF_ST_IDLE;
      end
      WSF_ST_FENCE: begin
        if (fence_ok) begin
          next_done = 1'b1;
          next_state = WSF_ST_IDLE;
        end
      end
      WSF_ST_PROBE: begin
        if (fire) begin
          next_state = WSF_ST_PROBE_WAIT;
        end
      end
      WSF_ST_PROBE_WAIT: begin
        if (probe_resp_i) begin
          next_state = probe_dirty_i ? WSF_ST_WRBACK : WSF_ST_INVAL;
        end
      end
      WSF_ST_WRBACK: begin
        if (fire) begin
          next_state = WSF_ST_INVAL;
        end
      end
      WSF_ST_INVAL: begin
        if (fire) begin
          next_done = 1'b1;
          next_state = WSF_ST_IDLE;
        end
      end
    endcase
  end

  // visibility counters; issue and acknowledge in one cycle cancel out
  always_comb begin
    logic st_issue, ld_issue, fl_issue;
    st_issue = fire && (mem_cmd_o inside {WSF_CMD_WRITE, WSF_CMD_WRITE_INPLACE,
                                          WSF_CMD_WRITE_LINE, WSF_CMD_EVICT});
    ld_issue = fire && (mem_cmd_o == WSF_CMD_READ);
    fl_issue = fire && (mem_cmd_o == WSF_CMD_INVAL);
    next_st_pend = st_pend + CNT_W'(st_issue) - CNT_W'(store_vis_i);
    next_ld_pend = ld_pend + CNT_W'(ld_issue) - CNT_W'(load_vis_i);
    next_fl_pend = fl_pend + CNT_W'(fl_issue) - CNT_W'(flush_vis_i);
    next_load_valid = load_vis_i;
    next_load_data = load_vis_i ? load_data_i : load_data;
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      state <= WSF_ST_IDLE;
      op_q <= WSF_OP_LOAD;
      cmd_q <= WSF_CMD_NONE;
      addr_q <= '0;
      data_q <= '0;
      be_q <= '0;
      alloc_q <= 1'b0;
      done <= 1'b0;
      gp_fault <= 1'b0;
      page_fault <= 1'b0;
      st_pend <= '0;
      ld_pend <= '0;
      fl_pend <= '0;
      load_valid <= 1'b0;
      load_data <= '0;
    end else if (ce_i) begin
      state <= next_state;
      op_q <= next_op_q;
      cmd_q <= next_cmd_q;
      addr_q <= next_addr_q;
      data_q <= next_data_q;
      be_q <= next_be_q;
      alloc_q <= next_alloc_q;
      done <= next_done;
      gp_fault <= next_gp_fault;
      page_fault <= next_page_fault;
      st_pend <= next_st_pend;
      ld_pend <= next_ld_pend;
      fl_pend <= next_fl_pend;
      load_valid <= next_load_valid;
      load_data <= next_load_data;
    end
  end

  assign done_o = done;
  assign gp_fault_o = gp_fault;
  assign page_fault_o = page_fault;
  assign load_valid_o = load_valid;
  assign load_data_o = load_data;
endmodule

//--- wsf_map.svh
// constants for the weak store, fence and flush unit
`ifndef WSF_MAP_SVH
`define WSF_MAP_SVH
`define WSF_LINE_BYTES 64
`define WSF_LINE_OFS_BITS 6
`define WSF_UNIT_BYTES 16
`define WSF_NT_PS_ALIGN_BITS 4
`define WSF_QWORD_BYTES 8
`define WSF_CNT_W 4
`define WSF_ADDR_W 32
`endif

//--- wsf_pkg.sv
// types shared by the weak store, fence and flush unit
package wsf_pkg;
  // operations offered by the pipeline
  typedef enum logic [3:0] {
    WSF_OP_LOAD,
    WSF_OP_STORE,
    WSF_OP_NT_PS,
    WSF_OP_NT_DQ,
    WSF_OP_NT_Q,
    WSF_OP_NT_MASK,
    WSF_OP_SFENCE,
    WSF_OP_LFENCE,
    WSF_OP_MFENCE,
    WSF_OP_FLUSH
  } wsf_op_t;
  // memory attribute of the target page
  typedef enum logic [2:0] {
    WSF_MT_WB,
    WSF_MT_WT,
    WSF_MT_UC,
    WSF_MT_WP,
    WSF_MT_WRITE_COMBINING_TYPE
  } wsf_mtype_t;
  // commands toward the cache hierarchy and memory
  typedef enum logic [2:0] {
    WSF_CMD_NONE,
    WSF_CMD_READ,
    WSF_CMD_WRITE,
    WSF_CMD_WRITE_INPLACE,
    WSF_CMD_WRITE_LINE,
    WSF_CMD_EVICT,
    WSF_CMD_PROBE,
    WSF_CMD_INVAL
  } wsf_cmd_t;
endpackage

//--- wsf_wc_buffer.sv
// one-line write-combining buffer for streaming stores
`timescale 1ns/1ps
`include "wsf_map.svh"
module wsf_wc_buffer import wsf_pkg::*; #(
  parameter int LINE_BYTES = `WSF_LINE_BYTES,
  parameter int ADDR_W = `WSF_ADDR_W
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic merge_i,
  input wire logic clear_i,
  input wire logic [ADDR_W-1:0] line_addr_i,
  input wire logic [LINE_BYTES*8-1:0] data_i,
  input wire logic [LINE_BYTES-1:0] be_i,
  output logic valid_o,
  output logic [ADDR_W-1:0] line_addr_o,
  output logic [LINE_BYTES*8-1:0] data_o,
  output logic [LINE_BYTES-1:0] be_o
);
  logic [7:0] bytes [LINE_BYTES];
  logic [7:0] next_bytes [LINE_BYTES];
  logic [LINE_BYTES-1:0] be;
  logic [LINE_BYTES-1:0] next_be;
  logic [ADDR_W-1:0] line;
  logic [ADDR_W-1:0] next_line;

  // later bytes overwrite earlier ones; clear runs first so drain and refill may share a cycle
  always_comb begin
    next_bytes = bytes;
    next_be = clear_i ? '0 : be;
    next_line = line;
    if (merge_i) begin
      next_line = line_addr_i;
      for (int i = 0; i < LINE_BYTES; i++) begin
        if (be_i[i]) begin
          next_bytes[i] = data_i[i*8 +: 8];
          next_be[i] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      be <= '0;
      line <= '0;
      for (int i = 0; i < LINE_BYTES; i++) begin
        bytes[i] <= 8'h00;
      end
    end else if (ce_i) begin
      be <= next_be;
      line <= next_line;
      bytes <= next_bytes;
    end
  end

  always_comb begin
    for (int i = 0; i < LINE_BYTES; i++) begin
      data_o[i*8 +: 8] = bytes[i];
    end
  end

  assign valid_o = |be;
  assign be_o = be;
  assign line_addr_o = line;
endmodule

//--- wsf_unit_properties.sv
// assertion checker for the weak store, fence and flush unit
`timescale 1ns/1ps
module wsf_unit_properties import wsf_pkg::*; #(
  parameter int ADDR_W = 32,
  parameter int LINE_BYTES = 64
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic op_valid_i,
  input wire logic op_ready_o,
  input wire wsf_op_t op_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire wsf_mtype_t mem_type_i,
  input wire logic xlat_fault_i,
  input wire logic done_o,
  input wire logic gp_fault_o,
  input wire logic page_fault_o,
  input wire logic mem_valid_o,
  input wire logic mem_ready_i,
  input wire wsf_cmd_t mem_cmd_o,
  input wire logic [ADDR_W-1:0] mem_addr_o,
  input wire logic [LINE_BYTES-1:0] mem_be_o,
  input wire logic mem_alloc_o,
  input wire logic mem_bcast_o,
  input wire logic probe_resp_i,
  input wire logic probe_dirty_i,
  input wire logic load_vis_i,
  input wire logic store_vis_i,
  input wire logic flush_vis_i
);
  logic take, hs;
  wsf_op_t last_op;
  wsf_mtype_t last_mt;
  logic [7:0] n_ld, n_st, n_fl;
  assign take = ce_i && op_valid_i && op_ready_o;
  assign hs = ce_i && mem_valid_o && mem_ready_i;
  // outstanding traffic, frozen with the unit while ce_i is low
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      last_op <= WSF_OP_LOAD;
      last_mt <= WSF_MT_WB;
      n_ld <= 8'h00;
      n_st <= 8'h00;
      n_fl <= 8'h00;
    end else if (ce_i) begin
      if (take) begin
        last_op <= op_i;
        last_mt <= mem_type_i;
      end
      n_ld <= n_ld + 8'(hs && mem_cmd_o == WSF_CMD_READ) - 8'(load_vis_i);
      n_st <= n_st + 8'(hs && mem_cmd_o inside {WSF_CMD_WRITE, WSF_CMD_WRITE_INPLACE,
        WSF_CMD_WRITE_LINE, WSF_CMD_EVICT}) - 8'(store_vis_i);
      n_fl <= n_fl + 8'(hs && mem_cmd_o == WSF_CMD_INVAL) - 8'(flush_vis_i);
    end
  end
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (reset_i);
  sequence s_dirty_probe;
    probe_resp_i && probe_dirty_i && last_op == WSF_OP_FLUSH;
  endsequence
  sequence s_line_wb;
    mem_valid_o && mem_cmd_o == WSF_CMD_WRITE_LINE && (&mem_be_o);
  endsequence
  property p_gp;
    take && op_i == WSF_OP_NT_PS && addr_i[3:0] != 4'h0 && !xlat_fault_i
      |=> done_o && gp_fault_o && !mem_valid_o;
  endproperty
  a_gp: assert property (p_gp)
    else $error("misaligned store did not fault");
  property p_nt_alloc;
    hs && last_op inside {WSF_OP_NT_PS, WSF_OP_NT_DQ, WSF_OP_NT_Q, WSF_OP_NT_MASK}
      && mem_cmd_o inside {WSF_CMD_WRITE, WSF_CMD_WRITE_LINE} |-> !mem_alloc_o;
  endproperty
  a_nt_alloc: assert property (p_nt_alloc)
    else $error("streaming write allocates");
  property p_line;
    mem_valid_o |-> mem_addr_o[5:0] == 6'h00;
  endproperty
  a_line: assert property (p_line)
    else $error("request not line aligned");
  property p_bcast;
    mem_valid_o && mem_cmd_o == WSF_CMD_INVAL |-> mem_bcast_o;
  endproperty
  a_bcast: assert property (p_bcast)
    else $error("invalidate not broadcast");
  property p_dirty_wb;
    s_dirty_probe |-> ##[1:4] s_line_wb;
  endproperty
  a_dirty_wb: assert property (p_dirty_wb)
    else $error("dirty line not written back");
  property p_sfence;
    done_o && last_op == WSF_OP_SFENCE |-> n_st == 8'h00;
  endproperty
  a_sfence: assert property (p_sfence)
    else $error("store fence ended with stores pending");
  property p_lfence;
    done_o && last_op == WSF_OP_LFENCE |-> n_ld == 8'h00;
  endproperty
  a_lfence: assert property (p_lfence)
    else $error("load fence ended with loads pending");
  property p_mfence;
    done_o && last_op == WSF_OP_MFENCE |-> n_ld == 8'h00 && n_st == 8'h00 && n_fl == 8'h00;
  endproperty
  a_mfence: assert property (p_mfence)
    else $error("full fence ended with traffic pending");
  property p_lf_quick;
    take && op_i == WSF_OP_LFENCE && n_ld == 8'h00 |-> ##[1:3] done_o;
  endproperty
  a_lf_quick: assert property (p_lf_quick)
    else $error("load fence waited without loads");
  property p_pfault;
    take && xlat_fault_i && op_i == WSF_OP_FLUSH |=> done_o && page_fault_o;
  endproperty
  a_pfault: assert property (p_pfault)
    else $error("flush fault missing");
  property p_wc_read;
    mem_valid_o && mem_cmd_o == WSF_CMD_READ && last_mt == WSF_MT_WRITE_COMBINING_TYPE
      |-> !mem_alloc_o;
  endproperty
  a_wc_read: assert property (p_wc_read)
    else $error("combining read allocates");
endmodule
bind wsf_unit wsf_unit_properties #(.ADDR_W(ADDR_W), .LINE_BYTES(LINE_BYTES)) u_props (
  .clock_i, .reset_i, .ce_i, .op_valid_i, .op_ready_o, .op_i, .addr_i, .mem_type_i,
  .xlat_fault_i, .done_o, .gp_fault_o, .page_fault_o, .mem_valid_o, .mem_ready_i,
  .mem_cmd_o, .mem_addr_o, .mem_be_o, .mem_alloc_o, .mem_bcast_o, .probe_resp_i,
  .probe_dirty_i, .load_vis_i, .store_vis_i, .flush_vis_i);

//--- wsf_mem_model.sv
// behavioural model of the cache hierarchy, memory and coherent agents
`timescale 1ns/1ps
module wsf_mem_model import wsf_pkg::*; #(
  parameter logic [127:0] LOAD_WORD = 128'h0
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic slow_i,
  input wire logic dirty_i,
  input wire logic mem_valid_i,
  input wire wsf_cmd_t mem_cmd_i,
  output logic mem_ready_o,
  output logic probe_resp_o,
  output logic probe_dirty_o,
  output logic load_vis_o,
  output logic store_vis_o,
  output logic flush_vis_o,
  output logic [127:0] load_data_o
);
  logic [1:0] wait_q;
  logic [4:0] tick;
  logic [7:0] n_ld, n_st, n_fl;
  logic hs, pl, st;
  // slow mode makes each request wait three cycles
  assign mem_ready_o = mem_valid_i && (!slow_i || wait_q == 2'h3);
  assign hs = mem_valid_i && mem_ready_o;
  assign st = mem_cmd_i inside {WSF_CMD_WRITE, WSF_CMD_WRITE_INPLACE, WSF_CMD_WRITE_LINE,
    WSF_CMD_EVICT};
  // one visibility pulse per class a period, never with nothing pending
  assign pl = slow_i ? tick == 5'h00 : tick[1:0] == 2'h0;
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      wait_q <= 2'h0;
      tick <= 5'h00;
      {n_ld, n_st, n_fl} <= 24'h0;
      {probe_resp_o, probe_dirty_o, load_vis_o, store_vis_o, flush_vis_o} <= 5'h0;
      load_data_o <= 128'h0;
    end else begin
      wait_q <= (mem_valid_i && !hs) ? wait_q + 2'h1 : 2'h0;
      tick <= tick + 5'h01;
      probe_resp_o <= hs && mem_cmd_i == WSF_CMD_PROBE;
      // answer lines wander while nothing is answered
      probe_dirty_o <= (hs && mem_cmd_i == WSF_CMD_PROBE) ? dirty_i : ~probe_dirty_o;
      load_data_o <= (pl && n_ld != 8'h00) ? LOAD_WORD : ~load_data_o;
      load_vis_o <= pl && n_ld != 8'h00;
      store_vis_o <= pl && n_st != 8'h00;
      flush_vis_o <= pl && n_fl != 8'h00;
      n_ld <= n_ld + 8'(hs && mem_cmd_i == WSF_CMD_READ) - 8'(pl && n_ld != 8'h00);
      n_st <= n_st + 8'(hs && st) - 8'(pl && n_st != 8'h00);
      n_fl <= n_fl + 8'(hs && mem_cmd_i == WSF_CMD_INVAL) - 8'(pl && n_fl != 8'h00);
    end
  end
endmodule

//--- wsf_unit_tb.sv
// self-checking testbench of the weak store, fence and flush unit
`timescale 1ns/1ps
module wsf_unit_tb import wsf_pkg::*; ();
  localparam logic [127:0] D0 = 128'h0f1e_2d3c_4b5a_6978_8796_a5b4_c3d2_e1f0;
  localparam logic [127:0] D1 = 128'h1122_3344_5566_7788_99aa_bbcc_ddee_ff00;
  localparam logic [127:0] LW = 128'hfeed_0000_1111_2222_3333_4444_5555_cafe;
  typedef struct {wsf_cmd_t c; logic [31:0] a; logic [63:0] be; logic [511:0] d;
    logic al; logic bc;} wsf_hs_t;
  logic clock_i = 1'b0, reset_i = 1'b1, ce_i = 1'b1, op_valid_i = 1'b0, xlat_fault_i = 1'b0;
  logic slow = 1'b0, dirty = 1'b0, gp, pf, op_ready_o, done_o, gp_fault_o, page_fault_o;
  wsf_op_t op_i = WSF_OP_LOAD;
  wsf_mtype_t mem_type_i = WSF_MT_WB;
  wsf_cmd_t mem_cmd_o;
  logic [31:0] addr_i = 32'h0, dest_index_i = 32'h0, mem_addr_o;
  logic [127:0] data_i = 128'h0, mask_i = 128'h0, load_data_i, load_data_o;
  logic mem_valid_o, mem_ready_i, mem_alloc_o, mem_bcast_o, probe_resp_i, probe_dirty_i;
  logic load_vis_i, store_vis_i, flush_vis_i, load_valid_o;
  logic [511:0] mem_wdata_o;
  logic [63:0] mem_be_o;
  int n_errors = 0, check_count = 0, cyc, lv = 0;
  wsf_hs_t lg[$], r;
  always #12.5 clock_i = ~clock_i;
  wsf_unit u_dut (.clock_i, .reset_i, .ce_i, .op_valid_i, .op_ready_o, .op_i, .addr_i,
    .dest_index_i, .data_i, .mask_i, .mem_type_i, .xlat_fault_i, .done_o, .gp_fault_o,
    .page_fault_o, .mem_valid_o, .mem_ready_i, .mem_cmd_o, .mem_addr_o, .mem_wdata_o,
    .mem_be_o, .mem_alloc_o, .mem_bcast_o, .probe_resp_i, .probe_dirty_i, .load_vis_i,
    .store_vis_i, .flush_vis_i, .load_data_i, .load_valid_o, .load_data_o);
  wsf_mem_model #(.LOAD_WORD(LW)) u_mem (.clock_i, .reset_i, .slow_i(slow), .dirty_i(dirty),
    .mem_valid_i(mem_valid_o), .mem_cmd_i(mem_cmd_o), .mem_ready_o(mem_ready_i),
    .probe_resp_o(probe_resp_i), .probe_dirty_o(probe_dirty_i), .load_vis_o(load_vis_i),
    .store_vis_o(store_vis_i), .flush_vis_o(flush_vis_i), .load_data_o(load_data_i));
  // log every accepted memory request in order
  always @(posedge clock_i) begin
    lv += load_valid_o;
    if (mem_valid_o && mem_ready_i && ce_i)
      lg.push_back('{mem_cmd_o, mem_addr_o, mem_be_o, mem_wdata_o, mem_alloc_o, mem_bcast_o});
  end
  task automatic give_verdict();
    if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic ck(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("Error %0t: %s", $time, m);
    end
  endtask
  // one op: hold the request until taken, then wait for done under a bound
  task automatic op(input wsf_op_t o, input logic [31:0] a, input logic [127:0] d,
      input wsf_mtype_t mt);
    int i;
    @(posedge clock_i);
    op_valid_i <= 1'b1;
    op_i <= o;
    addr_i <= a;
    data_i <= d;
    mem_type_i <= mt;
    i = 0;
    do begin @(negedge clock_i); i++; end while (op_ready_o !== 1'b1 && i < 200);
    @(posedge clock_i);
    op_valid_i <= 1'b0;
    cyc = 0;
    do begin @(negedge clock_i); cyc++; end while (done_o !== 1'b1 && cyc < 200);
    gp = gp_fault_o;
    pf = page_fault_o;
    if (i >= 200 || cyc >= 200) begin
      ck(1'b0, "op timed out");
      give_verdict();
    end
  endtask
  task automatic pop(input wsf_cmd_t c, input logic [31:0] a);
    r.c = WSF_CMD_NONE;
    if (lg.size() != 0) r = lg.pop_front();
    ck(r.c === c && r.a === a, "wrong memory request");
  endtask
  task automatic s_ps();
    op(WSF_OP_NT_PS, 32'h104, D0, WSF_MT_WRITE_COMBINING_TYPE);
    ck(gp === 1'b1 && lg.size() == 0, "misaligned store not refused");
    op(WSF_OP_NT_PS, 32'h110, D0, WSF_MT_WRITE_COMBINING_TYPE);
    ck(gp === 1'b0 && lg.size() == 0, "aligned store not combined");
    op(WSF_OP_SFENCE, 32'h0, D0, WSF_MT_WB);
    pop(WSF_CMD_WRITE_LINE, 32'h100);
    ck(r.be === 64'hffff_0000 && r.d[255:128] === D0 && !r.al, "16 byte line");
  endtask
  task automatic s_merge();
    op(WSF_OP_NT_DQ, 32'h200, D0, WSF_MT_WRITE_COMBINING_TYPE);
    op(WSF_OP_NT_DQ, 32'h200, D1, WSF_MT_WRITE_COMBINING_TYPE);
    op(WSF_OP_NT_Q, 32'h228, D1, WSF_MT_WRITE_COMBINING_TYPE);
    op(WSF_OP_SFENCE, 32'h0, D0, WSF_MT_WB);
    pop(WSF_CMD_WRITE_LINE, 32'h200);
    ck(r.be === 64'h0000_ff00_0000_ffff && r.d[127:0] === D1
      && r.d[383:320] === D1[63:0], "merge or collapse");
  endtask
  task automatic s_mask();
    @(posedge clock_i);
    mask_i <= 128'h8000_0000_0000_0000_0000_0000_00ff_7f80;
    dest_index_i <= 32'h2c0;
    op(WSF_OP_NT_MASK, 32'h9990, D0, WSF_MT_WRITE_COMBINING_TYPE);
    op(WSF_OP_SFENCE, 32'h0, D0, WSF_MT_WB);
    pop(WSF_CMD_WRITE_LINE, 32'h2c0);
    ck(r.be === 64'h8005 && r.d[23:16] === D0[23:16], "masked bytes");
  endtask
  task automatic s_evict();
    op(WSF_OP_NT_DQ, 32'h300, D0, WSF_MT_WB);
    pop(WSF_CMD_EVICT, 32'h300);
    op(WSF_OP_SFENCE, 32'h0, D0, WSF_MT_WB);
    pop(WSF_CMD_WRITE_LINE, 32'h300);
    ck(r.be === 64'hffff && !r.al, "evicted line write");
    op(WSF_OP_NT_DQ, 32'h344, D1, WSF_MT_UC);
    pop(WSF_CMD_WRITE, 32'h340);
    ck(r.be === 64'hffff0 && !r.al, "uncached streaming write");
  endtask
  task automatic s_flush();
    for (int k = 0; k < 2; k++) begin
      @(posedge clock_i);
      dirty <= (k == 0);
      op(WSF_OP_MFENCE, 32'h0, D0, WSF_MT_WB);
      op(WSF_OP_FLUSH, 32'h1234, D0, k ? WSF_MT_WRITE_COMBINING_TYPE : WSF_MT_WB);
      op(WSF_OP_MFENCE, 32'h0, D0, WSF_MT_WB);
      pop(WSF_CMD_PROBE, 32'h1200);
      if (k == 0) begin
        pop(WSF_CMD_WRITE_LINE, 32'h1200);
        ck(r.be === 64'hffff_ffff_ffff_ffff, "write back not whole line");
      end
      pop(WSF_CMD_INVAL, 32'h1200);
      ck(r.bc === 1'b1, "invalidate not broadcast");
    end
    @(posedge clock_i);
    xlat_fault_i <= 1'b1;
    op(WSF_OP_FLUSH, 32'h1234, D0, WSF_MT_WB);
    ck(pf === 1'b1 && lg.size() == 0, "flush fault");
    @(posedge clock_i);
    xlat_fault_i <= 1'b0;
  endtask
  task automatic s_load();
    @(posedge clock_i);
    slow <= 1'b1;
    op(WSF_OP_NT_DQ, 32'h500, D0, WSF_MT_UC);
    pop(WSF_CMD_WRITE, 32'h500);
    op(WSF_OP_LFENCE, 32'h0, D0, WSF_MT_WB);
    ck(cyc < 4, "load fence waited for stores");
    op(WSF_OP_LOAD, 32'h400, D0, WSF_MT_WRITE_COMBINING_TYPE);
    pop(WSF_CMD_READ, 32'h400);
    ck(r.al === 1'b0, "combining read allocates");
    op(WSF_OP_LFENCE, 32'h0, D0, WSF_MT_WB);
    ck(load_data_o === LW && lv == 1, "load data not back at fence end");
    op(WSF_OP_LOAD, 32'h440, D0, WSF_MT_WB);
    pop(WSF_CMD_READ, 32'h440);
    ck(r.al === 1'b1, "cacheable read not allocating");
    @(posedge clock_i);
    slow <= 1'b0;
  endtask
  initial begin
    repeat (6) @(posedge clock_i);
    ck(op_ready_o === 1'b1 && mem_valid_o === 1'b0 && done_o === 1'b0, "reset state");
    reset_i <= 1'b0;
    @(posedge clock_i);
    ce_i <= 1'b0;
    @(negedge clock_i);
    ck(op_ready_o === 1'b0, "ready while frozen");
    @(posedge clock_i);
    ce_i <= 1'b1;
    s_ps();
    s_merge();
    s_mask();
    s_evict();
    s_flush();
    s_load();
    give_verdict();
  end
endmodule
